// ==== hdl/stmc_map.vh ====
// Purpose: Offsets, field positions, reset values and timing figures of the
//          switch threshold and matrix configuration bank.
// Assumes: Core clock of 125 MHz; 24-bit register words.
// Notes:   Operation
// Operation
// - Map register at 0x30, bits 23-21 zero.
// - Three-bit code n picks threshold level n.
// - Sense channel selections at bits 20-9.
// - Upper group selections C, B, A at 8-0.
// - Matrix register at 0x31, bits 23-17 zero.
// - Two-bit field picks crossing interrupt condition.
// - Shared limit is ten bits, 14 down to 5.
// - Size field: none, 4x4, 5x5, 6x6.
// - Poll code maps 64 to 1360 microseconds.
// - Method register at 0x32, resets to zero.
// - Method bit: 0 comparator, 1 ADC.
`ifndef STMC_MAP_VH
`define STMC_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Register offsets and reset values.
`define STMC_ADDR_MAP_UPPER 8'h30
`define STMC_ADDR_GRID_SETUP 8'h31
`define STMC_ADDR_METHOD 8'h32
`define STMC_RESET_WORD 24'h000000

////////////////////////////////////////////////////////////////////////////////
// Writable bit masks; reserved positions are zero.
`define STMC_MAP_WMASK 24'h1fffff
`define STMC_GRID_WMASK 24'h01ffff
`define STMC_METHOD_WMASK 24'hffffff

////////////////////////////////////////////////////////////////////////////////
// Field positions.
`define STMC_SEL_WIDTH 3
`define STMC_SEL_COUNT 7
`define STMC_IRQ_SEL_LSB 15
`define STMC_LIMIT_LSB 5
`define STMC_LIMIT_MSB 14
`define STMC_SIZE_LSB 3
`define STMC_POLL_LSB 0

////////////////////////////////////////////////////////////////////////////////
// Crossing interrupt selections.
`define STMC_IRQ_NONE 2'h0
`define STMC_IRQ_RISE 2'h1
`define STMC_IRQ_FALL 2'h2
`define STMC_IRQ_BOTH 2'h3

////////////////////////////////////////////////////////////////////////////////
// Matrix sizes and their side length.
`define STMC_DIM_NONE 3'h0
`define STMC_DIM_4 3'h4
`define STMC_DIM_5 3'h5
`define STMC_DIM_6 3'h6

////////////////////////////////////////////////////////////////////////////////
// Poll active times in microseconds and the cycle count derived from them.
`define STMC_CLK_MHZ 125
`define STMC_POLL_US0 64
`define STMC_POLL_US1 128
`define STMC_POLL_US2 256
`define STMC_POLL_US3 384
`define STMC_POLL_US4 512
`define STMC_POLL_US5 768
`define STMC_POLL_US6 1024
`define STMC_POLL_US7 1360
`define STMC_US_TO_CYC(us) ((us) * `STMC_CLK_MHZ)

`endif

// ==== hdl/stmc_level_sel.v ====
// Purpose: Picks one of eight programmable threshold levels by a 3-bit code.
// Assumes: Level n sits at bits 10n+9 down to 10n of the table.
// Notes:   Purely combinational; the caller registers the result.
`default_nettype none

module stmc_level_sel
(
    // Selection
    input wire [2:0] code,
    input wire [79:0] level_table,
    // Result
    output reg [9:0] level
);

    always @*
    begin
        case (code)
            3'h0: level = level_table[9:0];
            3'h1: level = level_table[19:10];
            3'h2: level = level_table[29:20];
            3'h3: level = level_table[39:30];
            3'h4: level = level_table[49:40];
            3'h5: level = level_table[59:50];
            3'h6: level = level_table[69:60];
            default: level = level_table[79:70];
        endcase
    end

endmodule // stmc_level_sel

`default_nettype wire

// ==== hdl/stmc_cross_det.v ====
// Purpose: Detects crossings of the shared limit by successive conversions.
// Assumes: A conversion is announced by a one-cycle valid.
// Notes:   Above means strictly greater than the limit.
`include "stmc_map.vh"
`default_nettype none

module stmc_cross_det
(
    // Clock and control
    input wire clk,
    input wire rst_n,
    input wire ce,
    // Conversion results
    input wire sample_valid,
    input wire [9:0] sample,
    input wire [9:0] limit,
    input wire [1:0] irq_sel,
    // Event outputs
    output reg cross_pulse,
    output reg cross_rise
);

    reg prev_valid_reg;
    reg prev_above_reg;
    wire now_above;
    wire rise_hit;
    wire fall_hit;

    assign now_above = (sample > limit);
    // The first result after reset has no history, so it never flags.
    assign rise_hit = prev_valid_reg && !prev_above_reg && now_above;
    assign fall_hit = prev_valid_reg && prev_above_reg && !now_above;

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            prev_valid_reg <= 1'b0;
            prev_above_reg <= 1'b0;
            cross_pulse <= 1'b0;
            cross_rise <= 1'b0;
        end
        else if (ce)
        begin
            cross_pulse <= 1'b0;
            if (sample_valid)
            begin
                prev_valid_reg <= 1'b1;
                prev_above_reg <= now_above;
                if (rise_hit && irq_sel[0])
                begin
                    cross_pulse <= 1'b1;
                    cross_rise <= 1'b1;
                end
                else if (fall_hit && irq_sel[1])
                begin
                    cross_pulse <= 1'b1;
                    cross_rise <= 1'b0;
                end
            end
        end
    end

endmodule // stmc_cross_det

`default_nettype wire

// ==== hdl/stmc_top.v ====
// Purpose: Threshold map, matrix setup and detection method registers.
// Assumes: The serial frame decoder presents single-cycle register strobes.
// Notes:   All outputs are registered; CLK_EN low freezes every flop.
`include "stmc_map.vh"
`default_nettype none

module stmc_top
#(
    parameter [17:0] POLL_CYC0 = `STMC_US_TO_CYC(`STMC_POLL_US0),
    parameter [17:0] POLL_CYC1 = `STMC_US_TO_CYC(`STMC_POLL_US1),
    parameter [17:0] POLL_CYC2 = `STMC_US_TO_CYC(`STMC_POLL_US2),
    parameter [17:0] POLL_CYC3 = `STMC_US_TO_CYC(`STMC_POLL_US3),
    parameter [17:0] POLL_CYC4 = `STMC_US_TO_CYC(`STMC_POLL_US4),
    parameter [17:0] POLL_CYC5 = `STMC_US_TO_CYC(`STMC_POLL_US5),
    parameter [17:0] POLL_CYC6 = `STMC_US_TO_CYC(`STMC_POLL_US6),
    parameter [17:0] POLL_CYC7 = `STMC_US_TO_CYC(`STMC_POLL_US7)
)
(
    // Clock, reset and enable
    input wire CORE_CLK,
    input wire RST_N,
    input wire CLK_EN,
    // Register port from the serial frame decoder
    input wire [7:0] REG_ADDR,
    input wire [23:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [23:0] REG_RDATA,
    output reg REG_RVALID,
    // Programmable threshold levels, level n at bits 10n+9:10n
    input wire [79:0] LEVEL_TABLE,
    // Conversion results for the shared limit check
    input wire CONV_VALID,
    input wire [9:0] CONV_DATA,
    // Threshold map outputs, selection k at bits 3k+2:3k
    output reg [20:0] SELECT_CODES,
    output reg [69:0] SELECTED_LEVELS,
    // Shared limit outputs
    output reg [9:0] SHARED_LIMIT,
    output reg [1:0] SHARED_LIMIT_IRQ_SEL,
    output wire SHARED_CROSS_IRQ,
    output wire SHARED_CROSS_RISE,
    // Matrix outputs
    output reg [1:0] GRID_SIZE,
    output reg [2:0] GRID_DIM,
    output reg [2:0] GRID_POLL_ON_TIME,
    output reg [17:0] GRID_POLL_CYCLES,
    // Detection method per input
    output reg [23:0] INPUT_METHOD
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode, used for both reads and writes.

    function [1:0] reg_index;
        input [7:0] addr;
        begin
            if (addr == `STMC_ADDR_MAP_UPPER)
                reg_index = 2'h1;
            else if (addr == `STMC_ADDR_GRID_SETUP)
                reg_index = 2'h2;
            else if (addr == `STMC_ADDR_METHOD)
                reg_index = 2'h3;
            else
                reg_index = 2'h0;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register storage.

    reg [23:0] map_upper_reg;
    reg [23:0] grid_setup_reg;
    reg [23:0] method_reg;
    reg [23:0] map_upper_next;
    reg [23:0] grid_setup_next;
    reg [23:0] method_next;
    reg [23:0] rdata_next;
    wire [1:0] wr_idx;
    wire [1:0] rd_idx;

    assign wr_idx = reg_index(REG_ADDR);
    assign rd_idx = wr_idx;

    // Only writable bits are taken; reserved bits stay zero by construction.
    always @*
    begin
        map_upper_next = map_upper_reg;
        grid_setup_next = grid_setup_reg;
        method_next = method_reg;
        if (REG_WR)
        begin
            if (wr_idx == 2'h1)
                map_upper_next = REG_WDATA & `STMC_MAP_WMASK;
            else if (wr_idx == 2'h2)
                grid_setup_next = REG_WDATA & `STMC_GRID_WMASK;
            else if (wr_idx == 2'h3)
                method_next = REG_WDATA & `STMC_METHOD_WMASK;
        end
    end

    // Reads return the stored word; unmapped addresses read as zero.
    always @*
    begin
        if (rd_idx == 2'h1)
            rdata_next = map_upper_reg;
        else if (rd_idx == 2'h2)
            rdata_next = grid_setup_reg;
        else if (rd_idx == 2'h3)
            rdata_next = method_reg;
        else
            rdata_next = 24'h000000;
    end

    always @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            map_upper_reg <= `STMC_RESET_WORD;
            grid_setup_reg <= `STMC_RESET_WORD;
            method_reg <= `STMC_RESET_WORD;
            REG_RDATA <= 24'h000000;
            REG_RVALID <= 1'b0;
        end
        else if (CLK_EN)
        begin
            map_upper_reg <= map_upper_next;
            grid_setup_reg <= grid_setup_next;
            method_reg <= method_next;
            REG_RVALID <= REG_RD;
            if (REG_RD)
                REG_RDATA <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Threshold map fields. Selections 0-2 are upper group A, B, C; 3-4 are
    // the first sense channel A, B; 5-6 the second sense channel A, B.

    wire [69:0] level_pick;

    genvar k;
    generate
        for (k = 0; k < `STMC_SEL_COUNT; k = k + 1)
        begin : g_sel
            stmc_level_sel u_sel
            (
                .code(map_upper_reg[3*k+2:3*k]),
                .level_table(LEVEL_TABLE),
                .level(level_pick[10*k+9:10*k])
            );
        end
    endgenerate

    always @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            SELECT_CODES <= 21'h000000;
            SELECTED_LEVELS <= 70'h0;
        end
        else if (CLK_EN)
        begin
            SELECT_CODES <= map_upper_reg[20:0];
            SELECTED_LEVELS <= level_pick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Matrix setup fields.

    wire [1:0] irq_sel_fld;
    wire [9:0] limit_fld;
    wire [1:0] size_fld;
    wire [2:0] poll_fld;
    reg [2:0] dim_next;
    reg [17:0] poll_cyc_next;

    assign irq_sel_fld = grid_setup_reg[`STMC_IRQ_SEL_LSB+1:`STMC_IRQ_SEL_LSB];
    assign limit_fld = grid_setup_reg[`STMC_LIMIT_MSB:`STMC_LIMIT_LSB];
    assign size_fld = grid_setup_reg[`STMC_SIZE_LSB+1:`STMC_SIZE_LSB];
    assign poll_fld = grid_setup_reg[`STMC_POLL_LSB+2:`STMC_POLL_LSB];

    always @*
    begin
        case (size_fld)
            2'h0: dim_next = `STMC_DIM_NONE;
            2'h1: dim_next = `STMC_DIM_4;
            2'h2: dim_next = `STMC_DIM_5;
            default: dim_next = `STMC_DIM_6;
        endcase
    end

    // The poll time leaves as a cycle count so the poll engine needs no table.
    always @*
    begin
        case (poll_fld)
            3'h0: poll_cyc_next = POLL_CYC0;
            3'h1: poll_cyc_next = POLL_CYC1;
            3'h2: poll_cyc_next = POLL_CYC2;
            3'h3: poll_cyc_next = POLL_CYC3;
            3'h4: poll_cyc_next = POLL_CYC4;
            3'h5: poll_cyc_next = POLL_CYC5;
            3'h6: poll_cyc_next = POLL_CYC6;
            default: poll_cyc_next = POLL_CYC7;
        endcase
    end

    always @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            SHARED_LIMIT <= 10'h000;
            SHARED_LIMIT_IRQ_SEL <= `STMC_IRQ_NONE;
            GRID_SIZE <= 2'h0;
            GRID_DIM <= `STMC_DIM_NONE;
            GRID_POLL_ON_TIME <= 3'h0;
            GRID_POLL_CYCLES <= POLL_CYC0;
            INPUT_METHOD <= 24'h000000;
        end
        else if (CLK_EN)
        begin
            SHARED_LIMIT <= limit_fld;
            SHARED_LIMIT_IRQ_SEL <= irq_sel_fld;
            GRID_SIZE <= size_fld;
            GRID_DIM <= dim_next;
            GRID_POLL_ON_TIME <= poll_fld;
            GRID_POLL_CYCLES <= poll_cyc_next;
            INPUT_METHOD <= method_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared limit crossing. The detector compares against the live register
    // so a new limit takes effect on the very next conversion.

    stmc_cross_det u_cross
    (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .ce(CLK_EN),
        .sample_valid(CONV_VALID),
        .sample(CONV_DATA),
        .limit(limit_fld),
        .irq_sel(irq_sel_fld),
        .cross_pulse(SHARED_CROSS_IRQ),
        .cross_rise(SHARED_CROSS_RISE)
    );

endmodule // stmc_top

`default_nettype wire

// ==== tb/stmc_checker.sv ====
// Purpose: Concurrent checks on the register port and derived outputs of stmc_top.
// Assumes: One clock domain; sees only the top module ports.
// Notes:   Bound to every stmc_top instance at the foot of this file.
`default_nettype none

module stmc_checker
(
    // Clock, reset and enable
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [23:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [23:0] REG_RDATA,
    input wire logic REG_RVALID,
    // Conversions and derived outputs
    input wire logic CONV_VALID,
    input wire logic SHARED_CROSS_IRQ,
    input wire logic [9:0] SHARED_LIMIT,
    input wire logic [1:0] GRID_SIZE,
    input wire logic [2:0] GRID_DIM,
    input wire logic [2:0] GRID_POLL_ON_TIME,
    input wire logic [17:0] GRID_POLL_CYCLES,
    input wire logic [23:0] INPUT_METHOD
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    // Expected poll time in cycles: microseconds times 125 cycles each.
    function automatic logic [17:0] poll_exp(input logic [2:0] code);
        case (code)
            3'h0: return 18'(64 * 125);
            3'h1: return 18'(128 * 125);
            3'h2: return 18'(256 * 125);
            3'h3: return 18'(384 * 125);
            3'h4: return 18'(512 * 125);
            3'h5: return 18'(768 * 125);
            3'h6: return 18'(1024 * 125);
            default: return 18'(1360 * 125);
        endcase
    endfunction

    wire grid_wr = CLK_EN && REG_WR && REG_ADDR == 8'h31;
    wire meth_wr = CLK_EN && REG_WR && REG_ADDR == 8'h32;

    a_read_latency: assert property (CLK_EN && REG_RD |=> REG_RVALID)
        else $error("read answer missing");
    a_map_reserved: assert property (REG_RVALID && $past(REG_ADDR) == 8'h30 |-> REG_RDATA[23:21] == 3'h0)
        else $error("map register reserved bits not zero");
    a_grid_reserved: assert property (REG_RVALID && $past(REG_ADDR) == 8'h31 |-> REG_RDATA[23:17] == 7'h0)
        else $error("matrix register reserved bits not zero");
    a_limit_follows: assert property (grid_wr ##1 CLK_EN |=> SHARED_LIMIT == $past(REG_WDATA[14:5], 2))
        else $error("shared limit does not follow write");
    a_size_dim: assert property (GRID_DIM == (GRID_SIZE == 2'h0 ? 3'h0 : {1'b0, GRID_SIZE} + 3'h3))
        else $error("matrix side length does not match size code");
    a_poll_map: assert property (GRID_POLL_CYCLES == poll_exp(GRID_POLL_ON_TIME))
        else $error("poll cycles do not match poll code");
    a_method_copy: assert property (meth_wr ##1 CLK_EN |=> INPUT_METHOD == $past(REG_WDATA, 2))
        else $error("method output does not follow write");
    a_irq_cause: assert property (SHARED_CROSS_IRQ |-> $past(CONV_VALID && CLK_EN))
        else $error("crossing event without a conversion");

    c_irq: cover property (SHARED_CROSS_IRQ);
    c_grid_wr: cover property (grid_wr);
    c_read_data: cover property (REG_RVALID && REG_RDATA != 24'h0);
endmodule // stmc_checker

bind stmc_top stmc_checker chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
    .CLK_EN(CLK_EN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .CONV_VALID(CONV_VALID),
    .SHARED_CROSS_IRQ(SHARED_CROSS_IRQ), .SHARED_LIMIT(SHARED_LIMIT), .GRID_SIZE(GRID_SIZE),
    .GRID_DIM(GRID_DIM), .GRID_POLL_ON_TIME(GRID_POLL_ON_TIME),
    .GRID_POLL_CYCLES(GRID_POLL_CYCLES), .INPUT_METHOD(INPUT_METHOD));
`default_nettype wire

// ==== tb/stmc_host.sv ====
// Purpose: Host model issuing register writes and reads on the register port.
// Assumes: Requests change at the falling edge and are taken at the next rising edge.
// Notes:   Released address and data show their inverse so stale values never match.
`default_nettype none

module stmc_host
(
    // Clock and answer
    input wire logic clk,
    input wire logic [23:0] rdata,
    input wire logic rvalid,
    // Request
    output logic [7:0] addr,
    output logic [23:0] wdata,
    output logic wr,
    output logic rd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        addr = 8'h00;
        wdata = 24'h000000;
        wr = 1'b0;
        rd = 1'b0;
    end

    task automatic write_reg(input logic [7:0] a, input logic [23:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask

    // The answer is registered at the taking edge and lasts one cycle, so it is
    // read at the falling edge that follows, before the strobe is released.
    task automatic read_reg(input logic [7:0] a, output logic [23:0] d, output logic v);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        d = rdata;
        v = rvalid;
        rd = 1'b0;
        addr = ~a;
    endtask
endmodule // stmc_host
`default_nettype wire

// ==== tb/switch_threshold_matrix_config_bench.sv ====
// Purpose: Self-checking bench for the threshold map and matrix registers.
// Assumes: Poll counts at their default of 125 cycles per microsecond.
// Notes:   Inputs change at the falling edge only.
`default_nettype none

module switch_threshold_matrix_config_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic conv_valid = 1'b0;
    logic [9:0] conv_data = 10'h000;
    logic [79:0] level_table;
    logic [7:0] addr;
    logic [23:0] wdata, rdata, method, rd_val;
    logic wr, rd, rvalid, irq, rise, rd_ok;
    logic [20:0] sel_codes;
    logic [69:0] sel_levels;
    logic [9:0] limit;
    logic [1:0] irq_sel, grid_size;
    logic [2:0] grid_dim, poll_time;
    logic [17:0] poll_cyc;
    int errors = 0;
    int n_tests = 0;

    stmc_top dut (
        .CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
        .LEVEL_TABLE(level_table), .CONV_VALID(conv_valid), .CONV_DATA(conv_data),
        .SELECT_CODES(sel_codes), .SELECTED_LEVELS(sel_levels), .SHARED_LIMIT(limit),
        .SHARED_LIMIT_IRQ_SEL(irq_sel), .SHARED_CROSS_IRQ(irq), .SHARED_CROSS_RISE(rise),
        .GRID_SIZE(grid_size), .GRID_DIM(grid_dim), .GRID_POLL_ON_TIME(poll_time),
        .GRID_POLL_CYCLES(poll_cyc), .INPUT_METHOD(method));
    stmc_host host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [9:0] lvl(input int n);
        return 10'((n % 8) * 73 + 11);
    endfunction

    function automatic logic [17:0] poll_exp(input logic [2:0] code);
        case (code)
            3'h0: return 18'(64 * 125);
            3'h1: return 18'(128 * 125);
            3'h2: return 18'(256 * 125);
            3'h3: return 18'(384 * 125);
            3'h4: return 18'(512 * 125);
            3'h5: return 18'(768 * 125);
            3'h6: return 18'(1024 * 125);
            default: return 18'(1360 * 125);
        endcase
    endfunction

    task automatic check(input logic [69:0] got, input logic [69:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("Mismatches %0d of %0d comparisons", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        host.read_reg(8'h30, rd_val, rd_ok);
        check(rd_val, 24'h0);
        host.read_reg(8'h31, rd_val, rd_ok);
        check(rd_val, 24'h0);
        host.read_reg(8'h32, rd_val, rd_ok);
        check(rd_val, 24'h0);
        check(poll_cyc, poll_exp(3'h0));
    endtask

    // Each field gets a different code so that swapped fields show up.
    task automatic t_map();
        logic [20:0] f;
        logic [69:0] lv;
        for (int c = 0; c < 8; c++)
        begin
            for (int k = 0; k < 7; k++)
            begin
                f[3 * k +: 3] = 3'(c + k);
                lv[10 * k +: 10] = lvl(c + k);
            end
            host.write_reg(8'h30, {3'h7, f});
            host.read_reg(8'h30, rd_val, rd_ok);
            check(rd_val, {3'h0, f});
            check(sel_codes, f);
            check(sel_levels, lv);
        end
    endtask

    task automatic t_grid();
        logic [16:0] f;
        for (int c = 0; c < 8; c++)
        begin
            f = {2'(c), 10'(c * 111 + 7), 2'(c + 1), 3'(7 - c)};
            host.write_reg(8'h31, {7'h7f, f});
            host.read_reg(8'h31, rd_val, rd_ok);
            check(rd_val, {7'h0, f});
            check(irq_sel, f[16:15]);
            check(limit, f[14:5]);
            check(grid_size, f[4:3]);
            check(grid_dim, f[4:3] == 2'h0 ? 3'h0 : 3'(f[4:3]) + 3'h3);
            check(poll_time, f[2:0]);
            check(poll_cyc, poll_exp(3'(7 - c)));
        end
    endtask

    task automatic t_method();
        host.write_reg(8'h32, 24'ha5c3e1);
        host.write_reg(8'h33, 24'hffffff);
        host.read_reg(8'h32, rd_val, rd_ok);
        check({rd_ok, rd_val}, {1'b1, 24'ha5c3e1});
        check(method, 24'ha5c3e1);
        host.read_reg(8'h33, rd_val, rd_ok);
        check({rd_ok, rd_val}, 25'h1000000);
        // Let the answer pulse end first, since a frozen flop would hold it high.
        @(negedge clk);
        clk_en = 1'b0;
        host.write_reg(8'h32, 24'h0);
        host.read_reg(8'h32, rd_val, rd_ok);
        check({rd_ok, method}, {1'b0, 24'ha5c3e1});
        clk_en = 1'b1;
        host.read_reg(8'h32, rd_val, rd_ok);
        check({rd_ok, rd_val}, {1'b1, 24'ha5c3e1});
    endtask

    task automatic conv(input logic [9:0] d, input logic exp_irq, input logic exp_rise);
        @(negedge clk);
        conv_valid = 1'b1;
        conv_data = d;
        @(negedge clk);
        check(irq, exp_irq);
        if (exp_irq)
            check(rise, exp_rise);
        conv_valid = 1'b0;
        conv_data = ~d;
    endtask

    // A value equal to the limit is not above it, so 100 and 101 straddle it.
    task automatic t_cross();
        for (int s = 0; s < 4; s++)
        begin
            host.write_reg(8'h31, {7'h0, 2'(s), 10'd100, 5'h0});
            conv(10'd100, 1'b0, 1'b0);
            conv(10'd101, s[0], 1'b1);
            conv(10'd100, s[1], 1'b0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #4 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        complete_run();
    end

    initial
    begin
        for (int n = 0; n < 8; n++)
            level_table[10 * n +: 10] = lvl(n);
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_map();
        t_grid();
        t_method();
        t_cross();
        complete_run();
    end
endmodule // switch_threshold_matrix_config_bench
`default_nettype wire
